// ===== logic/bpc_regs.svh
`ifndef BPC_REGS_SVH
`define BPC_REGS_SVH
`define BPC_CMD_OFFSET   8'h04
`define BPC_CMD_RESET    16'h0000
`define BPC_BIT_IO       0
`define BPC_BIT_MEM      1
`define BPC_BIT_MASTER   2
`define BPC_BIT_SPECIAL  3
`define BPC_BIT_MWI      4
`define BPC_BIT_PALETTE  5
`define BPC_BIT_PARITY   6
`define BPC_BIT_WAIT     7
`define BPC_BIT_SERR     8
`define BPC_BIT_FBB      9
`define BPC_BIT_INTDIS   10
`define BPC_RW_MASK_FWD  16'h0147
`define BPC_RW_MASK_REV  16'h0567
`define BPC_PAL_A0       10'h3c6
`define BPC_PAL_A1       10'h3c8
`define BPC_PAL_A2       10'h3c9
`define BPC_IRQ_IDLE     4'hf
`define BPC_SERR_IDLE    1'b1
`endif

// ===== logic/bpc_pkg.sv
package bpc_pkg;
  typedef struct packed {
    logic       valid;
    logic       is_io;
    logic       is_mem_rd;
    logic       is_write;
    logic       is_special;
    logic [9:0] addr_lo;
  } bpc_req_t;

  typedef struct packed {
    logic       valid;
    logic       is_split_cpl;
    logic       is_mwi;
    logic       forwarded;
  } bpc_init_t;

  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] rdata;
    logic        rvalid;
    logic        accept;
    logic        sec_accept;
    logic        init_grant;
    logic        mwi_ok;
    logic        mdpe;
    logic        err_msg;
    logic        serr_n;
    logic [3:0]  irq_n;
  } bpc_state_t;
endpackage

// ===== logic/bpc_command.sv
// Operation
// - With the I/O enable clear, primary I/O requests are not claimed except palette snoop writes.
// - The memory enable gates acceptance of primary memory reads.
// - With bus master clear, no secondary response and no primary start except split completions.
// - With bus master set, forwarded secondary requests start on primary.
// - Split completions in reverse PCI-X mode start regardless of master.
// - Special cycle bit reads zero and special cycles are never claimed.
// - Write-and-invalidate bit reads zero; only forwarded ones pass.
// - In PCI-X mode no write-and-invalidate is passed, forwarded or not.
// - Palette snoop (reverse only) claims writes to 3c6h, 3c8h, 3c9h.
// - Parity response enable lets parity events raise the status flag.
// - Wait cycle bit reads zero.
// - Forward mode sends error messages only with system error enabled.
// - Reverse mode drives the system error line only when enabled.
// - Fast back-to-back bit reads zero.
// - Interrupt disable (reverse only) holds all four lines deasserted.
// - The master parity flag sets only with enable and a primary event.
`timescale 1ns/1ps
`include "bpc_regs.svh"
module bpc_command
  import bpc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        reverse_mode,
  input  wire logic        pcix_mode,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [1:0]  cfg_be,
  input  wire logic [15:0] cfg_wdata,
  output logic      [15:0] cfg_rdata,
  output logic             cfg_rvalid,
  input  wire bpc_req_t    pri_req,
  output logic             pri_accept,
  input  wire logic        sec_req,
  output logic             sec_accept,
  input  wire bpc_init_t   init_req,
  output logic             init_grant,
  output logic             mwi_ok,
  input  wire logic        parity_event,
  input  wire logic        mdpe_clear,
  output logic             mdpe_flag,
  input  wire logic        error_event,
  output logic             err_msg_send,
  output logic             system_error_out_n,
  input  wire logic [3:0]  irq_req,
  output logic             legacy_irq_a_n,
  output logic             legacy_irq_b_n,
  output logic             legacy_irq_c_n,
  output logic             legacy_irq_d_n
);

  bpc_state_t st_ff;
  bpc_state_t nxt_st;

  function automatic logic is_palette(input logic [9:0] a);
    is_palette = (a == `BPC_PAL_A0) || (a == `BPC_PAL_A1) ||
                 (a == `BPC_PAL_A2);
  endfunction

  logic [15:0] wmask;
  logic [15:0] bemask;
  logic        hit;
  logic        io_en;
  logic        mem_en;
  logic        mst_en;
  logic        pal_en;
  logic        par_en;
  logic        serr_en;
  logic        int_dis;

  always_comb begin
    // only writable bits survive each edge; reads mask again for the cycle after a mode switch
    wmask   = reverse_mode ? `BPC_RW_MASK_REV : `BPC_RW_MASK_FWD;
    bemask  = {{8{cfg_be[1]}}, {8{cfg_be[0]}}};
    hit     = (cfg_addr == `BPC_CMD_OFFSET);
    io_en   = st_ff.cmd[`BPC_BIT_IO];
    mem_en  = st_ff.cmd[`BPC_BIT_MEM];
    mst_en  = st_ff.cmd[`BPC_BIT_MASTER];
    pal_en  = st_ff.cmd[`BPC_BIT_PALETTE] & reverse_mode;
    par_en  = st_ff.cmd[`BPC_BIT_PARITY];
    serr_en = st_ff.cmd[`BPC_BIT_SERR];
    int_dis = st_ff.cmd[`BPC_BIT_INTDIS] & reverse_mode;
  end

  always_comb begin
    nxt_st = st_ff;
    // mode switch drops reverse-only bits on the next edge
    nxt_st.cmd = st_ff.cmd & wmask;
    if (cfg_wr && hit) begin
      nxt_st.cmd = ((st_ff.cmd & ~bemask) | (cfg_wdata & bemask))
                   & wmask;
    end
    nxt_st.rvalid = cfg_rd;
    // unmapped offsets read zero
    nxt_st.rdata = (cfg_rd && hit) ? (st_ff.cmd & wmask) : 16'h0000;

    nxt_st.accept = 1'b0;
    if (pri_req.valid && !pri_req.is_special) begin
      if (pri_req.is_io && io_en) begin
        nxt_st.accept = 1'b1;
      end else if (pri_req.is_io && pri_req.is_write && pal_en &&
                   is_palette(pri_req.addr_lo)) begin
        nxt_st.accept = 1'b1;
      end else if (pri_req.is_mem_rd && mem_en) begin
        nxt_st.accept = 1'b1;
      end
    end

    nxt_st.sec_accept = sec_req & mst_en;

    nxt_st.init_grant = 1'b0;
    nxt_st.mwi_ok     = 1'b0;
    if (init_req.valid) begin
      if (init_req.is_split_cpl && reverse_mode && pcix_mode) begin
        nxt_st.init_grant = 1'b1;
      end else if (mst_en && init_req.forwarded) begin
        nxt_st.init_grant = 1'b1;
      end
      // no self-originated mwi; in pci-x none is passed at all
      nxt_st.mwi_ok = init_req.is_mwi && init_req.forwarded &&
                      mst_en && !pcix_mode;
    end

    // set wins over clear
    if (parity_event && par_en) begin
      nxt_st.mdpe = 1'b1;
    end else if (mdpe_clear) begin
      nxt_st.mdpe = 1'b0;
    end

    nxt_st.err_msg = error_event & serr_en & ~reverse_mode;
    nxt_st.serr_n  = ~(error_event & serr_en & reverse_mode);
    nxt_st.irq_n   = int_dis ? `BPC_IRQ_IDLE : ~irq_req;

    if (rst) begin
      nxt_st            = '0;
      nxt_st.cmd        = `BPC_CMD_RESET;
      nxt_st.serr_n     = `BPC_SERR_IDLE;
      nxt_st.irq_n      = `BPC_IRQ_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    st_ff <= nxt_st;
  end

  assign cfg_rdata          = st_ff.rdata;
  assign cfg_rvalid         = st_ff.rvalid;
  assign pri_accept         = st_ff.accept;
  assign sec_accept         = st_ff.sec_accept;
  assign init_grant         = st_ff.init_grant;
  assign mwi_ok             = st_ff.mwi_ok;
  assign mdpe_flag          = st_ff.mdpe;
  assign err_msg_send       = st_ff.err_msg;
  assign system_error_out_n = st_ff.serr_n;
  assign legacy_irq_a_n     = st_ff.irq_n[0];
  assign legacy_irq_b_n     = st_ff.irq_n[1];
  assign legacy_irq_c_n     = st_ff.irq_n[2];
  assign legacy_irq_d_n     = st_ff.irq_n[3];

  // outputs are registered, so each check from an input looks one edge on
  chk_io_gate: assert property (
    @(posedge ref_clk) disable iff (rst)
    pri_req.valid && pri_req.is_io && !pri_req.is_write && !io_en
    |=> !pri_accept)
    else $error("io claimed while disabled");

  chk_io_claim: assert property (
    @(posedge ref_clk) disable iff (rst)
    pri_req.valid && pri_req.is_io && !pri_req.is_special && io_en
    |=> pri_accept)
    else $error("enabled io request not claimed");

  chk_mem_gate: assert property (
    @(posedge ref_clk) disable iff (rst)
    pri_req.valid && pri_req.is_mem_rd && !pri_req.is_io &&
    !pri_req.is_special |=> pri_accept == $past(mem_en))
    else $error("memory read gate wrong");

  chk_sec_gate: assert property (
    @(posedge ref_clk) disable iff (rst)
    sec_req |=> sec_accept == $past(mst_en))
    else $error("secondary response gate wrong");

  chk_mst_start: assert property (
    @(posedge ref_clk) disable iff (rst)
    !mst_en && !(init_req.is_split_cpl && reverse_mode && pcix_mode)
    |=> !init_grant)
    else $error("primary start without bus master");

  chk_fwd_start: assert property (
    @(posedge ref_clk) disable iff (rst)
    init_req.valid && init_req.forwarded && mst_en |=> init_grant)
    else $error("forwarded request not started");

  chk_split_cpl: assert property (
    @(posedge ref_clk) disable iff (rst)
    init_req.valid && init_req.is_split_cpl && reverse_mode && pcix_mode
    |=> init_grant)
    else $error("split completion blocked");

  chk_special: assert property (
    @(posedge ref_clk) disable iff (rst)
    pri_req.valid && pri_req.is_special |=> !pri_accept)
    else $error("special cycle claimed");

  chk_ro_zero: assert property (
    @(posedge ref_clk) disable iff (rst)
    cfg_rvalid |-> (cfg_rdata & ~`BPC_RW_MASK_REV) == 16'h0000)
    else $error("read-only bits nonzero");

  chk_mwi_own: assert property (
    @(posedge ref_clk) disable iff (rst)
    mwi_ok |-> $past(init_req.valid && init_req.is_mwi &&
    init_req.forwarded && mst_en))
    else $error("self-originated write and invalidate");

  chk_mwi_pcix: assert property (
    @(posedge ref_clk) disable iff (rst)
    pcix_mode |=> !mwi_ok)
    else $error("mwi in pci-x");

  chk_palette: assert property (
    @(posedge ref_clk) disable iff (rst)
    pri_req.valid && pri_req.is_io && pri_req.is_write && !io_en &&
    !pri_req.is_special |=> pri_accept == $past(pal_en &&
    is_palette(pri_req.addr_lo)))
    else $error("palette decode");

  chk_parity_set: assert property (
    @(posedge ref_clk) disable iff (rst)
    parity_event && par_en |=> mdpe_flag)
    else $error("enabled parity event lost");

  chk_mdpe_clear: assert property (
    @(posedge ref_clk) disable iff (rst)
    mdpe_clear && !(parity_event && par_en) |=> !mdpe_flag)
    else $error("parity flag not cleared");

  chk_mdpe_gate: assert property (
    @(posedge ref_clk) disable iff (rst)
    $rose(mdpe_flag) |-> $past(parity_event && par_en))
    else $error("parity flag without cause");

  chk_err_msg: assert property (
    @(posedge ref_clk) disable iff (rst)
    err_msg_send |-> $past(serr_en && !reverse_mode && error_event))
    else $error("error message while disabled");

  chk_err_send: assert property (
    @(posedge ref_clk) disable iff (rst)
    error_event && serr_en && !reverse_mode |=> err_msg_send)
    else $error("enabled error message lost");

  chk_serr_line: assert property (
    @(posedge ref_clk) disable iff (rst)
    !system_error_out_n |-> $past(serr_en && reverse_mode))
    else $error("serr line while disabled");

  chk_serr_drive: assert property (
    @(posedge ref_clk) disable iff (rst)
    error_event && serr_en && reverse_mode |=> !system_error_out_n)
    else $error("enabled system error not driven");

  chk_int_dis: assert property (
    @(posedge ref_clk) disable iff (rst)
    $past(int_dis) |-> {legacy_irq_a_n, legacy_irq_b_n, legacy_irq_c_n,
    legacy_irq_d_n} == `BPC_IRQ_IDLE)
    else $error("irq while disabled");

  chk_irq_follow: assert property (
    @(posedge ref_clk) disable iff (rst)
    !int_dis |=> {legacy_irq_d_n, legacy_irq_c_n, legacy_irq_b_n,
    legacy_irq_a_n} == ~$past(irq_req))
    else $error("irq lines do not follow requests");

  // forward mode must have dropped the reverse-only bits one edge later
  chk_rsv_hold: assert property (
    @(posedge ref_clk) disable iff (rst)
    !reverse_mode |=> (st_ff.cmd & ~`BPC_RW_MASK_FWD) == 16'h0000)
    else $error("locked command bits hold a one");

  chk_rd_pulse: assert property (
    @(posedge ref_clk) disable iff (rst)
    cfg_rd |=> cfg_rvalid)
    else $error("read not answered");

  chk_wr_land: assert property (
    @(posedge ref_clk) disable iff (rst)
    cfg_wr && hit && (cfg_be == 2'b11)
    |=> st_ff.cmd == $past(cfg_wdata & wmask))
    else $error("full write did not land");

  cov_io_claim: cover property (@(posedge ref_clk) disable iff (rst)
    pri_accept && $past(pri_req.is_io));
  cov_fwd_start: cover property (@(posedge ref_clk) disable iff (rst)
    init_grant && $past(mst_en));
  cov_serr: cover property (@(posedge ref_clk) disable iff (rst)
    !system_error_out_n);
  cov_mdpe: cover property (@(posedge ref_clk) disable iff (rst)
    $rose(mdpe_flag));
  cov_split: cover property (@(posedge ref_clk) disable iff (rst)
    init_grant && !$past(mst_en));
endmodule

// ===== tb/bpc_far_end.sv
`timescale 1ns/1ps
module bpc_far_end
  import bpc_pkg::*;
(
  input  wire logic ref_clk,
  output bpc_req_t  pri_req
);
  initial pri_req = '0;
  // released bus shows inverted address so stale values cannot match
  task automatic issue(input logic [3:0] k, input logic [9:0] a);
    // idle edge first, so back-to-back calls keep valid low for a cycle between
    @(negedge ref_clk);
    pri_req = {1'b1, k, a};
    @(negedge ref_clk);
    pri_req = {1'b0, 4'h0, ~a};
  endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb
  import bpc_pkg::*;
;
  logic        ref_clk, rst, reverse_mode, pcix_mode, cfg_wr, cfg_rd;
  logic        sec_req, parity_event, mdpe_clear, error_event;
  logic        cfg_rvalid, pri_accept, sec_accept, init_grant, mwi_ok;
  logic        mdpe_flag, err_msg_send, system_error_out_n;
  logic        legacy_irq_a_n, legacy_irq_b_n, legacy_irq_c_n, legacy_irq_d_n;
  logic [7:0]  cfg_addr;
  logic [1:0]  cfg_be;
  logic [15:0] cfg_wdata, cfg_rdata, r;
  logic [3:0]  irq_req;
  logic [9:0]  pa [4] = '{10'h3c6, 10'h3c7, 10'h3c8, 10'h3c9};
  logic        pe [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  logic [15:0] exp_q [$];
  bpc_req_t    pri_req;
  bpc_init_t   init_req;
  int          err_total, n_checks;
  integer      seed = 32'hb2ce1d22;

  bpc_far_end far (.ref_clk(ref_clk), .pri_req(pri_req));
  bpc_command uut (.ref_clk(ref_clk), .rst(rst),
    .reverse_mode(reverse_mode), .pcix_mode(pcix_mode), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .pri_req(pri_req), .pri_accept(pri_accept), .sec_req(sec_req),
    .sec_accept(sec_accept), .init_req(init_req), .init_grant(init_grant),
    .mwi_ok(mwi_ok), .parity_event(parity_event), .mdpe_clear(mdpe_clear),
    .mdpe_flag(mdpe_flag), .error_event(error_event),
    .err_msg_send(err_msg_send), .system_error_out_n(system_error_out_n),
    .irq_req(irq_req), .legacy_irq_a_n(legacy_irq_a_n),
    .legacy_irq_b_n(legacy_irq_b_n), .legacy_irq_c_n(legacy_irq_c_n),
    .legacy_irq_d_n(legacy_irq_d_n));

  initial begin
    ref_clk = 0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task chk1(input logic s, input logic e);
    chk({15'h0, s}, {15'h0, e});
  endtask
  task tk;
    @(negedge ref_clk);
  endtask
  // extra cycle keeps two strobes from landing in one time step
  task wr(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
    cfg_wr = 1; cfg_addr = a; cfg_be = b; cfg_wdata = d;
    tk; cfg_wr = 0; tk;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    cfg_rd = 1; cfg_addr = a; exp_q.push_back(e);
    tk; cfg_rd = 0; tk;
  endtask

  always @(negedge ref_clk) if (cfg_rvalid === 1'b1) begin
    if (exp_q.size() == 0) chk1(1'b0, 1'b1);
    else chk(cfg_rdata, exp_q.pop_front());
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    print_verdict;
  end

  initial begin
    rst = 1; reverse_mode = 0; pcix_mode = 0; cfg_wr = 0; cfg_rd = 0;
    cfg_addr = 0; cfg_be = 0; cfg_wdata = 0; sec_req = 0; init_req = '0;
    parity_event = 0; mdpe_clear = 0; error_event = 0; irq_req = 0;
    err_total = 0; n_checks = 0;
    repeat (6) tk;
    rst = 0;
    rd(8'h04, 16'h0000);
    wr(8'h04, 2'b11, 16'hffff);
    rd(8'h04, 16'h0147);
    for (int i = 0; i < 4; i++) begin
      r = 16'($random(seed));
      wr(8'h04, 2'b11, r);
      rd(8'h04, r & 16'h0147);
    end
    wr(8'h08, 2'b11, 16'h0000);
    rd(8'h08, 16'h0000);
    rd(8'h04, r & 16'h0147);
    reverse_mode = 1;
    wr(8'h04, 2'b11, 16'hffff);
    rd(8'h04, 16'h0567);
    wr(8'h04, 2'b01, 16'h0000);
    rd(8'h04, 16'h0500);
    reverse_mode = 0; tk;
    rd(8'h04, 16'h0100);
    reverse_mode = 1;
    wr(8'h04, 2'b11, 16'h0000);
    far.issue(4'b1000, 10'h000); chk1(pri_accept, 0);
    far.issue(4'b0100, 10'h000); chk1(pri_accept, 0);
    far.issue(4'b1010, 10'h3c6); chk1(pri_accept, 0);
    wr(8'h04, 2'b11, 16'h0020);
    for (int i = 0; i < 4; i++) begin
      far.issue(4'b1010, pa[i]); chk1(pri_accept, pe[i]);
    end
    far.issue(4'b1000, 10'h3c6); chk1(pri_accept, 0);
    wr(8'h04, 2'b11, 16'h0003);
    far.issue(4'b1001, 10'h000); chk1(pri_accept, 0);
    far.issue(4'b1000, 10'h000); chk1(pri_accept, 1);
    far.issue(4'b0100, 10'h000); chk1(pri_accept, 1);
    sec_req = 1; init_req = '{1'b1, 1'b0, 1'b1, 1'b1}; tk;
    chk1(sec_accept, 0); chk1(init_grant, 0); chk1(mwi_ok, 0);
    wr(8'h04, 2'b11, 16'h0004);
    chk1(sec_accept, 1); chk1(init_grant, 1); chk1(mwi_ok, 1);
    pcix_mode = 1; tk;
    chk1(mwi_ok, 0);
    sec_req = 0; init_req = '{1'b1, 1'b1, 1'b0, 1'b0};
    wr(8'h04, 2'b11, 16'h0000);
    chk1(init_grant, 1);
    pcix_mode = 0; tk;
    chk1(init_grant, 0);
    init_req = '0;
    parity_event = 1; tk; parity_event = 0; tk;
    chk1(mdpe_flag, 0);
    wr(8'h04, 2'b11, 16'h0040);
    parity_event = 1; tk; parity_event = 0; tk;
    chk1(mdpe_flag, 1);
    parity_event = 1; mdpe_clear = 1; tk;
    parity_event = 0; mdpe_clear = 0; tk;
    chk1(mdpe_flag, 1);
    mdpe_clear = 1; tk; mdpe_clear = 0; tk;
    chk1(mdpe_flag, 0);
    error_event = 1; tk; error_event = 0;
    chk1(system_error_out_n, 1);
    wr(8'h04, 2'b11, 16'h0140);
    error_event = 1; tk; error_event = 0;
    chk1(system_error_out_n, 0); chk1(err_msg_send, 0);
    reverse_mode = 0; tk;
    error_event = 1; tk; error_event = 0;
    chk1(err_msg_send, 1); chk1(system_error_out_n, 1);
    wr(8'h04, 2'b11, 16'h0000);
    error_event = 1; tk; error_event = 0;
    chk1(err_msg_send, 0);
    reverse_mode = 1; irq_req = 4'hf; tk;
    chk({12'h0, legacy_irq_d_n, legacy_irq_c_n, legacy_irq_b_n,
         legacy_irq_a_n}, 16'h0000);
    wr(8'h04, 2'b11, 16'h0400);
    chk({12'h0, legacy_irq_d_n, legacy_irq_c_n, legacy_irq_b_n,
         legacy_irq_a_n}, 16'h000f);
    chk1(exp_q.size() == 0, 1'b1);
    print_verdict;
  end
endmodule
